// file: pssp_pkg.sv
// package of constants for the pipelined sync sram port
package pssp_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int PAR_W = 4;
    localparam int BURST_W = 2;
    localparam logic [1:0] BURST_RST = 2'h0;
    localparam logic [1:0] BURST_ONE = 2'h1;
    localparam logic STRAP_LINEAR = 1'b0;
    localparam logic [2:0] SYNC_RST = 3'h6;
endpackage

// file: pssp_burst_seq.sv
// burst address sequencer: linear or interleaved order on the low address bits
`timescale 1ns/1ns
`default_nettype none
module pssp_burst_seq (
    input wire logic [pssp_pkg::BURST_W-1:0] start_i, // start bits captured with address
    input wire logic [pssp_pkg::BURST_W-1:0] count_i, // accesses advanced so far
    input wire logic linear_i,                       // high selects linear order
    output logic [pssp_pkg::BURST_W-1:0] bits_o      // resulting low address bits
);
    import pssp_pkg::*;
    always_comb begin
        if (linear_i) begin
            bits_o = start_i + count_i; // (R18) (R19)
        end else begin
            bits_o = start_i ^ count_i; // (R18)
        end
    end
endmodule // pssp_burst_seq
`default_nettype wire

// file: pssp_port.sv
// pipelined synchronous sram port: strobe capture, burst, data pipeline, output drive
//
// Contract
// (R1) controller address strobe sampled each rising edge, active low
// (R2) controller strobe capture latches the address register
// (R3) controller strobe capture loads the low two address bits into the burst counter
// (R4) both strobes active: processor strobe acts, controller strobe ignored
// (R5) sleep request high holds a quiet state, contents kept
// (R6) sleep request held low or undriven by the far side; undriven reads low
// (R7) write data and parity captured into data register on rising edge
// (R8) read data is the location addressed at the previous edge
// (R9) data and parity driven only while output enable input is low; code drives on the synchronised enable, two clocks behind the pin
// (R10) output enable high releases data and parity lines as inputs
// (R11) burst order strap low selects linear sequence
// (R12) strap high or open selects interleaved sequence
// (R13) far side keeps the burst order strap static
// (R14) processor strobe low captures address and loads burst counter
// (R15) processor strobe ignored when primary chip select is high
// (R16) burst advance low steps the burst counter
// (R17) first read clock after deselect keeps outputs off
// (R18) linear adds one mod four, interleaved xors start with count
// (R19) burst wraps after four, only the low two address bits change
`timescale 1ns/1ns
`default_nettype none
module pssp_port #(
    parameter int ADDR_W = pssp_pkg::ADDR_W, // address width
    parameter int DATA_W = pssp_pkg::DATA_W  // data width
) (
    input wire logic ref_clk_i,                          // device clock, 10 MHz
    input wire logic rst_i,                              // async reset, active high
    input wire logic [ADDR_W-1:0] addr_i,                // address lines
    input wire logic controller_addr_strobe_n_i,         // controller strobe, low active
    input wire logic processor_addr_strobe_n_i,          // processor strobe, low active
    input wire logic primary_chip_select_n_i,            // chip select, low active
    input wire logic burst_advance_n_i,                  // burst advance, low active
    input wire logic write_n_i,                          // write enable, low active
    input wire logic output_enable_n_i,                  // async output enable, low active
    input wire logic sleep_request_i,                    // sleep request, high active
    input wire logic burst_order_i,                      // strap: low linear, high interleaved
    input wire logic [DATA_W-1:0] data_i,                // data pins, input side
    output logic [DATA_W-1:0] data_o,                    // data pins, output side
    output logic data_oe_o,                              // data pins driven when high
    input wire logic [pssp_pkg::PAR_W-1:0] parity_io_i,  // parity pins, input side
    output logic [pssp_pkg::PAR_W-1:0] parity_io_o,      // parity pins, output side
    output logic parity_io_oe_o,                         // parity pins driven when high
    output logic sleep_o                                 // device in sleep state
);
    import pssp_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;
    localparam int WORD_W = DATA_W + PAR_W;

    // the array is a plain simulation memory, so the address width is capped
    initial begin
        if (ADDR_W < BURST_W || ADDR_W > 16) begin
            $error("pssp_port: address width out of range");
        end
        if (DATA_W < 1) begin
            $error("pssp_port: data width must be positive");
        end
        if (PAR_W < 1 || BURST_W != 2) begin
            $error("pssp_port: parity or burst width unsupported");
        end
    end

    // ************************************************
    // pin synchronisers
    // ************************************************
    // sleep and output enable are asynchronous pins; strap sampled too for safety
    // reset values: enable off, strap open (interleaved), not sleeping
    logic [2:0] pin_raw;
    wire [2:0] pin_sync;
    logic sleep_s;
    logic oe_n_s;
    logic order_s;

    assign pin_raw = {burst_order_i, output_enable_n_i, sleep_request_i}; // (R6)

    for (genvar g = 0; g < 3; g++) begin : g_sync
        logic meta_ff;
        logic sync_ff;
        logic nxt_meta;
        logic nxt_sync;
        always_comb begin
            nxt_meta = pin_raw[g];
            nxt_sync = meta_ff;
        end
        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                meta_ff <= SYNC_RST[g];
                sync_ff <= SYNC_RST[g];
            end else begin
                meta_ff <= nxt_meta;
                sync_ff <= nxt_sync;
            end
        end
        assign pin_sync[g] = sync_ff;
    end

    assign sleep_s = pin_sync[0];
    assign oe_n_s = pin_sync[1];
    assign order_s = pin_sync[2];

    // ************************************************
    // address and burst capture
    // ************************************************
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic [BURST_W-1:0] start_ff;
    logic [BURST_W-1:0] nxt_start;
    logic [BURST_W-1:0] count_ff;
    logic [BURST_W-1:0] nxt_count;
    logic sel_ff;
    logic nxt_sel;
    logic wr_ff;
    logic nxt_wr;
    logic rd_ff;
    logic nxt_rd;
    logic first_rd_ff;
    logic nxt_first_rd;
    logic proc_go;
    logic ctrl_go;
    logic [BURST_W-1:0] seq_bits;
    logic [ADDR_W-1:0] cur_addr;

    pssp_burst_seq u_seq (
        .start_i(start_ff),
        .count_i(count_ff),
        .linear_i(order_s == STRAP_LINEAR), // (R11) (R12)
        .bits_o(seq_bits)
    );

    assign cur_addr = {addr_ff[ADDR_W-1:BURST_W], seq_bits}; // (R19)

    // strobes of this edge; sleep refuses every request
    logic take;
    always_comb begin
        proc_go = !processor_addr_strobe_n_i && !primary_chip_select_n_i; // (R14) (R15)
        ctrl_go = !controller_addr_strobe_n_i && !proc_go; // (R1) (R4)
        take = (proc_go || ctrl_go) && !sleep_s;
    end

    always_comb begin
        nxt_addr = addr_ff;
        nxt_start = start_ff;
        nxt_count = count_ff;
        if (take) begin
            nxt_addr = addr_i; // (R2) (R14)
            nxt_start = addr_i[BURST_W-1:0]; // (R3) (R14)
            nxt_count = BURST_RST;
        end else if (!sleep_s && sel_ff && !burst_advance_n_i) begin
            nxt_count = count_ff + BURST_ONE; // (R16) (R19)
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_ff <= '0;
            start_ff <= BURST_RST;
            count_ff <= BURST_RST;
        end else begin
            addr_ff <= nxt_addr;
            start_ff <= nxt_start;
            count_ff <= nxt_count;
        end
    end

    // ************************************************
    // selection and access type
    // ************************************************
    always_comb begin
        nxt_sel = sel_ff;
        nxt_wr = 1'b0;
        nxt_rd = 1'b0;
        nxt_first_rd = 1'b0;
        if (sleep_s) begin
            nxt_sel = 1'b0; // (R5)
        end else if (take) begin
            nxt_sel = ctrl_go ? !primary_chip_select_n_i : 1'b1;
            // processor strobe cycles are reads; writes follow in later selected cycles with write low
            nxt_wr = ctrl_go && !write_n_i && !primary_chip_select_n_i;
            nxt_rd = nxt_sel && !nxt_wr;
            nxt_first_rd = nxt_rd && !sel_ff; // (R17)
        end else if (sel_ff) begin
            nxt_wr = !write_n_i;
            nxt_rd = write_n_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_ff <= 1'b0;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            first_rd_ff <= 1'b0;
        end else begin
            sel_ff <= nxt_sel;
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            first_rd_ff <= nxt_first_rd;
        end
    end

    // ************************************************
    // write data register and array
    // ************************************************
    logic [WORD_W-1:0] mem [DEPTH];
    logic [WORD_W-1:0] win_ff;
    logic [WORD_W-1:0] nxt_win;
    logic wpend_ff;
    logic nxt_wpend;
    logic [ADDR_W-1:0] waddr_ff;
    logic [ADDR_W-1:0] nxt_waddr;

    always_comb begin
        nxt_win = {parity_io_i, data_i}; // (R7)
        nxt_wpend = wr_ff;
        nxt_waddr = cur_addr;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            win_ff <= '0;
            wpend_ff <= 1'b0;
            waddr_ff <= '0;
        end else begin
            win_ff <= nxt_win;
            wpend_ff <= nxt_wpend;
            waddr_ff <= nxt_waddr;
        end
    end

    // array written one cycle late from the data register; memory kept in sleep
    always_ff @(posedge ref_clk_i) begin
        if (wpend_ff) begin
            mem[waddr_ff] <= win_ff; // (R5) (R7)
        end
    end

    // ************************************************
    // read pipeline
    // ************************************************
    logic [WORD_W-1:0] rdata_ff;
    logic [WORD_W-1:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic mask_ff;
    logic nxt_mask;

    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_rvalid = rd_ff;
        nxt_mask = first_rd_ff; // (R17)
        if (rd_ff) begin
            // forward a write still waiting for the array
            if (wpend_ff && waddr_ff == cur_addr) begin
                nxt_rdata = win_ff;
            end else begin
                nxt_rdata = mem[cur_addr]; // (R8)
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff <= '0;
            rvalid_ff <= 1'b0;
            mask_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            mask_ff <= nxt_mask;
        end
    end

    // ************************************************
    // output drive
    // ************************************************
    // enable follows the synchronised pin, so it lags the pin by two clocks
    logic drive;
    logic have_data;
    logic allowed;
    always_comb begin
        have_data = rvalid_ff && !mask_ff; // (R17)
        allowed = !oe_n_s && !sleep_s; // (R9) (R10)
        drive = have_data && allowed;
    end
    assign data_o = rdata_ff[DATA_W-1:0];
    assign parity_io_o = rdata_ff[WORD_W-1:DATA_W];
    assign data_oe_o = drive; // (R9)
    assign parity_io_oe_o = drive; // (R10)
    assign sleep_o = sleep_s; // (R5)
endmodule // pssp_port
`default_nettype wire

// file: pssp_port_props.sv
// assertions on the pins of the sram port
`timescale 1ns/1ns
`default_nettype none
module pssp_port_props (
    input wire logic ref_clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic controller_addr_strobe_n_i, // ctrl strobe
    input wire logic processor_addr_strobe_n_i, // proc strobe
    input wire logic primary_chip_select_n_i, // select
    input wire logic output_enable_n_i, // drive enable
    input wire logic sleep_request_i, // sleep in
    input wire logic data_oe_o, // data drive
    input wire logic parity_io_oe_o, // parity drive
    input wire logic sleep_o // sleep state
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_rst_quiet; disable iff (1'b0) rst_i |-> !data_oe_o && !sleep_o; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("drive in reset");
    property p_oe_off; output_enable_n_i [*3] |=> !data_oe_o; endproperty
    a_oe_off: assert property (p_oe_off) else $error("drive while disabled");
    property p_oe_need; data_oe_o |-> !$past(output_enable_n_i, 2); endproperty
    a_oe_need: assert property (p_oe_need) else $error("drive without enable");
    property p_par_oe; parity_io_oe_o == data_oe_o; endproperty
    a_par_oe: assert property (p_par_oe) else $error("parity drive differs");
    property p_slp_on; sleep_request_i [*4] |=> sleep_o; endproperty
    a_slp_on: assert property (p_slp_on) else $error("sleep not entered");
    property p_slp_off; !sleep_request_i [*4] |=> !sleep_o; endproperty
    a_slp_off: assert property (p_slp_off) else $error("sleep not left");
    property p_slp_quiet; sleep_o [*4] |-> !data_oe_o; endproperty
    a_slp_quiet: assert property (p_slp_quiet) else $error("drive in sleep");
    property p_desel;
        (!controller_addr_strobe_n_i && primary_chip_select_n_i && processor_addr_strobe_n_i) [*3]
            |=> !data_oe_o;
    endproperty
    a_desel: assert property (p_desel) else $error("drive after deselect");
endmodule // pssp_port_props
bind pssp_port pssp_port_props pssp_port_props_i (.ref_clk_i, .rst_i,
    .controller_addr_strobe_n_i, .processor_addr_strobe_n_i, .primary_chip_select_n_i,
    .output_enable_n_i, .sleep_request_i, .data_oe_o, .parity_io_oe_o, .sleep_o);
`default_nettype wire

// file: pssp_host_model.sv
// far-side bus model: resolves the shared data and parity wires
`timescale 1ns/1ns
`default_nettype none
module pssp_host_model (
    input wire logic ref_clk_i, // clock
    input wire logic drive_i, // host drives the wires
    input wire logic [35:0] wdata_i, // host write value
    input wire logic dev_oe_i, // device drives the wires
    input wire logic [35:0] dev_data_i, // device value
    output logic [35:0] bus_o // wire level seen by all
);
    logic [35:0] last_ff;
    // no pull here: an idle wire shows the inverse of its last level
    always_comb begin
        if (dev_oe_i) begin
            bus_o = dev_data_i;
        end else if (drive_i) begin
            bus_o = wdata_i;
        end else begin
            bus_o = ~last_ff;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        last_ff <= bus_o;
    end
endmodule // pssp_host_model
`default_nettype wire

// file: tb_pipelined_sync_sram_port.sv
// testbench for the sram port
`timescale 1ns/1ns
`default_nettype none
module tb_pipelined_sync_sram_port;
    logic clk, rst, cas_n, pas_n, cs_n, adv_n, we_n, oe_n, slp, mode, hen, oe, poe, slp_o;
    logic [9:0] addr;
    logic [35:0] hdat, bus;
    logic [31:0] dq_o;
    logic [3:0] dp_o;
    int error_cnt, tests_run;
    pssp_port pssp_port_i (.ref_clk_i(clk), .rst_i(rst), .addr_i(addr),
        .controller_addr_strobe_n_i(cas_n), .processor_addr_strobe_n_i(pas_n),
        .primary_chip_select_n_i(cs_n), .burst_advance_n_i(adv_n), .write_n_i(we_n),
        .output_enable_n_i(oe_n), .sleep_request_i(slp), .burst_order_i(mode),
        .data_i(bus[35:4]), .data_o(dq_o), .data_oe_o(oe), .parity_io_i(bus[3:0]),
        .parity_io_o(dp_o), .parity_io_oe_o(poe), .sleep_o(slp_o));
    pssp_host_model pssp_host_model_i (.ref_clk_i(clk), .drive_i(hen), .wdata_i(hdat),
        .dev_oe_i(oe), .dev_data_i({dq_o, dp_o}), .bus_o(bus));
    always #50 clk = ~clk;
    // ********************
    // bus tasks and scenarios
    // ********************
    function automatic logic [35:0] pat(input logic [9:0] a);
        return {22'h2a5c01, a, a[3:0]};
    endfunction
    task chk(input logic [35:0] got, input logic [35:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task do_reset(input logic m);
        @(posedge clk);
        rst <= 1'b1;
        mode <= m;
        repeat (20) @(posedge clk);
        #1 chk({34'h0, oe, slp_o}, 36'h0);
        @(posedge clk);
        rst <= 1'b0;
    endtask
    task wr(input logic [9:0] a, input logic [35:0] d);
        @(posedge clk);
        addr <= a;
        cas_n <= 1'b0;
        we_n <= 1'b0;
        @(posedge clk);
        cas_n <= 1'b1;
        we_n <= 1'b1;
        hen <= 1'b1;
        hdat <= d;
        @(posedge clk);
        hen <= 1'b0;
    endtask
    task rd(input logic [9:0] a);
        @(posedge clk);
        addr <= a;
        cas_n <= 1'b0;
        @(posedge clk);
        cas_n <= 1'b1;
        @(posedge clk);
        #1 chk({dq_o, dp_o}, pat(a));
    endtask
    task burst(input logic [9:0] base, input logic [1:0] s, input logic lin);
        logic [1:0] lo;
        for (int k = 0; k < 4; k++) wr(base + 10'(k), pat(base + 10'(k)));
        oe_n <= 1'b0;
        @(posedge clk);
        addr <= base | 10'(s);
        cas_n <= 1'b0;
        @(posedge clk);
        cas_n <= 1'b1;
        adv_n <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            if (k == 2) adv_n <= 1'b1;
            lo = lin ? s + 2'(k) : s ^ 2'(k);
            #1 chk({dq_o, dp_o}, pat({base[9:2], lo}));
        end
        chk({35'h0, oe}, 36'h1);
        @(posedge clk);
        oe_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task prio;
        wr(10'h0a5, pat(10'h0a5));
        @(posedge clk);
        addr <= 10'h0a5;
        cas_n <= 1'b0;
        pas_n <= 1'b0;
        we_n <= 1'b0;
        @(posedge clk);
        cas_n <= 1'b1;
        pas_n <= 1'b1;
        we_n <= 1'b1;
        hen <= 1'b1;
        hdat <= ~pat(10'h0a5);
        @(posedge clk);
        hen <= 1'b0;
        #1 chk({dq_o, dp_o}, pat(10'h0a5));
        rd(10'h0a5);
        @(posedge clk);
        oe_n <= 1'b0;
        cs_n <= 1'b1;
        cas_n <= 1'b0;
        repeat (3) @(posedge clk);
        cs_n <= 1'b0;
        cas_n <= 1'b1;
        rd(10'h0a5);
        chk({35'h0, oe}, 36'h0);
        @(posedge clk);
        oe_n <= 1'b1;
    endtask
    task sleep_test;
        @(posedge clk);
        oe_n <= 1'b0;
        slp <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk({35'h0, slp_o}, 36'h1);
        @(posedge clk);
        slp <= 1'b0;
        repeat (6) @(posedge clk);
        oe_n <= 1'b1;
        #1 chk({35'h0, slp_o}, 36'h0);
    endtask
    initial begin
        {clk, rst, cas_n, pas_n, cs_n, adv_n, we_n, oe_n, slp, mode, hen} = 11'h3ba;
        addr = 10'h0;
        hdat = 36'h0;
        error_cnt = 0;
        tests_run = 0;
        do_reset(1'b1);
        burst(10'h3f0, 2'h2, 1'b0);
        prio;
        sleep_test;
        do_reset(1'b0);
        burst(10'h150, 2'h3, 1'b1);
        stop_test;
    end
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        stop_test;
    end
endmodule // tb_pipelined_sync_sram_port
`default_nettype wire
